// *** design/dtpc_pkg.sv ***
// Package: constants and types of the DMA trigger and priority controller
package dtpc_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NCH = 8;
	localparam int CW = 3;
	localparam int DW = 16;
	localparam int AW = 5;
	localparam int NSRC = 16;
	localparam int CTL_W = 11;
	localparam int CHAIN_RING = 3;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [AW-1:0] ADR_GLOBAL = 5'h00;
	localparam logic [AW-1:0] ADR_DONE = 5'h01;
	localparam logic [AW-1:0] ADR_STATUS = 5'h02;
	localparam logic [AW-1:0] ADR_CTL_BASE = 5'h08;
	localparam logic [AW-1:0] ADR_CNT_BASE = 5'h10;

	// Global control bit positions
	localparam int GB_ROT = 0;
	localparam int GB_NMI = 1;
	localparam int GB_RMW = 2;
	localparam int GB_W = 3;
	// Status bit position of the busy flag, channel in the low bits
	localparam int SB_BUSY = 3;

	// ****************************************
	// Trigger source codes
	// ****************************************
	localparam logic [4:0] SRC_SWREQ = 5'h00;
	localparam logic [4:0] SRC_TMR1 = 5'h01;
	localparam logic [4:0] SRC_DAC = 5'h07;
	localparam logic [4:0] SRC_CONV = 5'h08;
	localparam logic [4:0] SRC_MPY = 5'h09;
	localparam logic [4:0] SRC_CHAIN = 5'h0a;
	localparam logic [4:0] SRC_EXT = 5'h0b;

	// Transfer mode field: bit 1 burst, bit 2 repeated, 000 single
	localparam int MB_BURST = 1;
	localparam int MB_REP = 2;
	localparam logic [2:0] MODE_SINGLE = 3'h0;
	localparam logic [2:0] MODE_REP_SINGLE = 3'h4;

	// Burst group wraps after four beats, CPU then runs two cycles
	localparam logic [1:0] BEAT_WRAP = 2'h0;
	localparam logic REL_LAST = 1'b1;
	localparam logic [DW-1:0] CNT_LAST = 16'h0001;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [4:0] trig_sel;
		logic sw_req;
		logic [2:0] mode;
		logic level;
		logic enable;
	} dtpc_ctl_type;

	typedef struct packed {
		logic [NSRC-1:0] flag;
		logic [NSRC-1:0] irq_en;
		logic conv_hw;
	} dtpc_periph_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SYNC = 3'h1,
		ST_XF1 = 3'h3,
		ST_XF2 = 3'h2,
		ST_WAIT = 3'h6,
		ST_REL = 3'h7
	} dtpc_state_type;
endpackage

// *** design/dtpc_core.sv ***
// Module: DMA trigger detection, CPU halt, priority and cycle sequencing
`timescale 1ns/10ps
`default_nettype none

module dtpc_core (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Register port
	input wire logic [dtpc_pkg::AW-1:0] i_addr,
	input wire logic [dtpc_pkg::DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [dtpc_pkg::DW-1:0] o_rdata,
	// Trigger sources
	input wire dtpc_pkg::dtpc_periph_type i_periph,
	input wire logic i_ext_trig,
	output logic [dtpc_pkg::NSRC-1:0] o_src_clear,
	output logic o_conv_mem_read,
	// CPU handshake
	input wire logic i_bus_released,
	input wire logic i_rmw_busy,
	input wire logic i_nmi,
	output logic o_halt_req,
	output logic o_irq_hold,
	// Main clock control
	input wire logic i_mclk_off,
	output logic o_mclk_restart,
	// Transfer strobe
	output logic o_xfer_valid,
	output logic [dtpc_pkg::CW-1:0] o_xfer_chan
);
	localparam int NCH = dtpc_pkg::NCH;
	localparam int CW = dtpc_pkg::CW;
	localparam int DW = dtpc_pkg::DW;
	localparam int CHAIN_RING_M1 = dtpc_pkg::CHAIN_RING - 1;

	// ****************************************
	// Functions
	// ****************************************
	// Address falls into an eight-register bank
	function automatic logic in_bank(input logic [dtpc_pkg::AW-1:0] a,
			input logic [dtpc_pkg::AW-1:0] base);
		in_bank = (a[dtpc_pkg::AW-1:CW] == base[dtpc_pkg::AW-1:CW]);
	endfunction

	// First requester at or after the start position, circular order
	function automatic logic [CW-1:0] pick(input logic [NCH-1:0] r,
			input logic [CW-1:0] s);
		logic [CW-1:0] c;
		c = s;
		pick = s;
		for (int i = NCH - 1; i >= 0; i--) begin
			c = s + CW'(i);
			if (r[c]) begin
				pick = c;
			end
		end
	endfunction

	// Level of the selected trigger source
	function automatic logic src_level(input logic [4:0] sel,
			input dtpc_pkg::dtpc_periph_type p, input logic sw,
			input logic chain, input logic ext);
		if (sel == dtpc_pkg::SRC_SWREQ) begin
			src_level = sw;
		end else if (sel >= dtpc_pkg::SRC_TMR1 && sel <= dtpc_pkg::SRC_DAC) begin
			src_level = p.flag[sel[3:0]] & ~p.irq_en[sel[3:0]];
		end else if (sel == dtpc_pkg::SRC_CONV) begin
			src_level = p.flag[sel[3:0]] & p.conv_hw;
		end else if (sel == dtpc_pkg::SRC_MPY) begin
			src_level = p.flag[sel[3:0]];
		end else if (sel == dtpc_pkg::SRC_CHAIN) begin
			src_level = chain;
		end else if (sel == dtpc_pkg::SRC_EXT) begin
			src_level = ext;
		end else begin
			src_level = 1'b0;
		end
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	dtpc_pkg::dtpc_state_type state;
	dtpc_pkg::dtpc_ctl_type ctl [NCH];
	logic [DW-1:0] cnt [NCH];
	logic [DW-1:0] tmp [NCH];
	logic [dtpc_pkg::GB_W-1:0] gctl;
	logic [NCH-1:0] done;
	logic [NCH-1:0] lvl;
	logic [NCH-1:0] prev;
	logic [NCH-1:0] pend;
	logic [NCH-1:0] in_block;
	logic [NCH-1:0] req;
	logic [NCH-1:0] wr_ctl;
	logic [NCH-1:0] wr_cnt;
	logic [CW-1:0] act;
	logic [CW-1:0] prio_start;
	logic [CW-1:0] gch;
	logic [1:0] beat;
	logic rel_cnt;
	logic last_r;
	logic grant;
	logic start;
	logic dec;
	logic last;
	logic abort;
	logic fin;
	dtpc_pkg::dtpc_ctl_type actc;
	dtpc_pkg::dtpc_ctl_type wctl;

	// ****************************************
	// Trigger detection per channel
	// ****************************************
	assign gch = pick(req, prio_start);
	assign grant = (state == dtpc_pkg::ST_IDLE) && (|req)
		&& !(gctl[dtpc_pkg::GB_RMW] && i_rmw_busy);
	assign start = grant && (cnt[gch] != '0);
	assign actc = ctl[act];
	assign wctl = dtpc_pkg::dtpc_ctl_type'(i_wdata[dtpc_pkg::CTL_W-1:0]);
	assign dec = (state == dtpc_pkg::ST_XF2);
	assign last = (cnt[act] == dtpc_pkg::CNT_LAST);

	generate
		for (genvar n = 0; n < NCH; n++) begin : g_ch
			logic chain;
			logic rise;
			logic busy_me;
			// Chain source only exists on the first three channels
			if (n == 0) begin : g_c0
				assign chain = done[CHAIN_RING_M1];
			end else if (n < dtpc_pkg::CHAIN_RING) begin : g_cn
				assign chain = done[n-1];
			end else begin : g_cx
				assign chain = 1'b0;
			end
			assign wr_ctl[n] = i_wr && in_bank(i_addr, dtpc_pkg::ADR_CTL_BASE)
				&& (i_addr[CW-1:0] == CW'(n));
			assign wr_cnt[n] = i_wr && in_bank(i_addr, dtpc_pkg::ADR_CNT_BASE)
				&& (i_addr[CW-1:0] == CW'(n));
			assign lvl[n] = src_level(ctl[n].trig_sel, i_periph, ctl[n].sw_req,
				chain, i_ext_trig);
			assign rise = lvl[n] && !prev[n];
			// Triggers during a running block are ignored
			assign busy_me = (state != dtpc_pkg::ST_IDLE) && (act == CW'(n))
				&& (ctl[n].mode != dtpc_pkg::MODE_SINGLE)
				&& (ctl[n].mode != dtpc_pkg::MODE_REP_SINGLE);
			assign req[n] = pend[n] || (ctl[n].enable && ctl[n].level
				&& lvl[n] && cnt[n] != '0);

			// Control word: software writes, hardware self-clears
			always_ff @(posedge i_ref_clk or posedge i_reset) begin
				if (i_reset) begin
					ctl[n] <= '0;
				end else if (wr_ctl[n]) begin
					ctl[n] <= dtpc_pkg::dtpc_ctl_type'(i_wdata[dtpc_pkg::CTL_W-1:0]);
				end else begin
					if (grant && gch == CW'(n)) begin
						ctl[n].sw_req <= 1'b0;
					end
					if (dec && act == CW'(n) && last && !ctl[n].mode[dtpc_pkg::MB_REP]) begin
						ctl[n].enable <= 1'b0;
					end
				end
			end

			// Count and its reload copy
			always_ff @(posedge i_ref_clk or posedge i_reset) begin
				if (i_reset) begin
					cnt[n] <= '0;
					tmp[n] <= '0;
				end else if (wr_cnt[n]) begin
					cnt[n] <= i_wdata;
					tmp[n] <= i_wdata;
				end else if (dec && act == CW'(n)) begin
					cnt[n] <= last ? tmp[n] : cnt[n] - 1'b1;
				end
			end

			// Edge sampling and held request; a reselect arms on the next rise,
			// except the request bit, whose write is itself the event
			always_ff @(posedge i_ref_clk or posedge i_reset) begin
				if (i_reset) begin
					prev[n] <= 1'b1;
					pend[n] <= 1'b0;
				end else begin
					prev[n] <= wr_ctl[n] ? (wctl.trig_sel != dtpc_pkg::SRC_SWREQ) : lvl[n];
					if (!ctl[n].enable || wr_ctl[n]) begin
						pend[n] <= 1'b0;
					end else if (rise && !ctl[n].level && !busy_me) begin
						pend[n] <= 1'b1;
					end else if (dec && act == CW'(n) && last
							&& ctl[n].mode[dtpc_pkg::MB_BURST] && ctl[n].mode[dtpc_pkg::MB_REP]) begin
						pend[n] <= 1'b1; // Repeated burst restarts without trigger
					end else if (grant && gch == CW'(n)) begin
						pend[n] <= 1'b0;
					end
				end
			end

			// Block progress kept while a level trigger is low
			always_ff @(posedge i_ref_clk or posedge i_reset) begin
				if (i_reset) begin
					in_block[n] <= 1'b0;
				end else if (wr_ctl[n] || wr_cnt[n] || (abort && act == CW'(n))) begin
					in_block[n] <= 1'b0;
				end else if (start && gch == CW'(n)) begin
					in_block[n] <= (ctl[n].mode != dtpc_pkg::MODE_SINGLE)
						&& (ctl[n].mode != dtpc_pkg::MODE_REP_SINGLE);
				end else if (dec && act == CW'(n) && last) begin
					in_block[n] <= 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// Transfer sequencer
	// ****************************************
	assign abort = (state != dtpc_pkg::ST_IDLE) && ((i_nmi && gctl[dtpc_pkg::GB_NMI])
		|| (actc.mode[dtpc_pkg::MB_BURST] && !actc.enable && !last_r));
	// Service ends after the last word, after one single word, or on level drop
	assign fin = last_r || !actc.mode[dtpc_pkg::MB_BURST] && !in_block[act]
		|| (actc.level && !lvl[act]);

	// Main state register, never preempted once a channel holds it
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			state <= dtpc_pkg::ST_IDLE;
			act <= '0;
		end else if (abort) begin
			state <= dtpc_pkg::ST_IDLE;
		end else begin
			case (state)
				dtpc_pkg::ST_IDLE: begin
					if (start) begin
						act <= gch;
						state <= dtpc_pkg::ST_SYNC;
					end
				end
				dtpc_pkg::ST_SYNC: begin
					if (i_bus_released) begin
						state <= dtpc_pkg::ST_XF1;
					end
				end
				dtpc_pkg::ST_XF1: begin
					state <= dtpc_pkg::ST_XF2;
				end
				dtpc_pkg::ST_XF2: begin
					state <= dtpc_pkg::ST_WAIT;
				end
				dtpc_pkg::ST_WAIT: begin
					if (fin) begin
						state <= dtpc_pkg::ST_IDLE;
					end else if (actc.mode[dtpc_pkg::MB_BURST] && beat == dtpc_pkg::BEAT_WRAP) begin
						state <= dtpc_pkg::ST_REL;
					end else begin
						state <= dtpc_pkg::ST_XF1;
					end
				end
				dtpc_pkg::ST_REL: begin
					if (rel_cnt == dtpc_pkg::REL_LAST) begin
						state <= dtpc_pkg::ST_SYNC;
					end
				end
				default: begin
					state <= dtpc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Beat counter within a burst group, release cycle counter, last word
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			beat <= '0;
			rel_cnt <= 1'b0;
			last_r <= 1'b0;
		end else begin
			if (start) begin
				beat <= '0;
			end else if (dec) begin
				beat <= beat + 1'b1;
			end
			rel_cnt <= (state == dtpc_pkg::ST_REL) ? dtpc_pkg::REL_LAST : 1'b0;
			if (dec) begin
				last_r <= last;
			end else if (state == dtpc_pkg::ST_IDLE) begin
				last_r <= 1'b0;
			end
		end
	end

	// Priority start point: follows the finished channel only when rotating
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			prio_start <= '0;
		end else if (!gctl[dtpc_pkg::GB_ROT]) begin
			prio_start <= '0;
		end else if (state == dtpc_pkg::ST_WAIT && fin && !abort) begin
			prio_start <= act + 1'b1;
		end
	end

	// Done flags: hardware set wins over a software clear
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			done <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (dec && last && act == CW'(i)) begin
					done[i] <= 1'b1;
				end else if (i_wr && i_addr == dtpc_pkg::ADR_DONE && i_wdata[i]) begin
					done[i] <= 1'b0;
				end
			end
		end
	end

	// Source flag clear at start and conversion memory access strobe
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_src_clear <= '0;
			o_conv_mem_read <= 1'b0;
		end else begin
			o_src_clear <= '0;
			if (start && ctl[gch].trig_sel >= dtpc_pkg::SRC_TMR1
					&& ctl[gch].trig_sel <= dtpc_pkg::SRC_DAC) begin
				o_src_clear[ctl[gch].trig_sel[3:0]] <= 1'b1;
			end
			o_conv_mem_read <= (state == dtpc_pkg::ST_XF1)
				&& (actc.trig_sel == dtpc_pkg::SRC_CONV);
		end
	end

	// Main clock wake for the whole service when it was stopped
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_mclk_restart <= 1'b0;
		end else if (start && i_mclk_off) begin
			o_mclk_restart <= 1'b1;
		end else if (state == dtpc_pkg::ST_IDLE) begin
			o_mclk_restart <= 1'b0;
		end
	end

	// CPU side: halt held from sync to wait, maskable interrupts held off
	assign o_halt_req = (state == dtpc_pkg::ST_SYNC) || (state == dtpc_pkg::ST_XF1)
		|| (state == dtpc_pkg::ST_XF2) || (state == dtpc_pkg::ST_WAIT);
	assign o_irq_hold = (state != dtpc_pkg::ST_IDLE);
	assign o_xfer_valid = (state == dtpc_pkg::ST_XF1);
	assign o_xfer_chan = act;

	// ****************************************
	// Register port
	// ****************************************
	// Global control
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			gctl <= '0;
		end else if (i_wr && i_addr == dtpc_pkg::ADR_GLOBAL) begin
			gctl <= i_wdata[dtpc_pkg::GB_W-1:0];
		end
	end

	// Read data one cycle after the strobe, zero elsewhere
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata <= '0;
		end else if (!i_rd) begin
			o_rdata <= '0;
		end else if (i_addr == dtpc_pkg::ADR_GLOBAL) begin
			o_rdata <= DW'(gctl);
		end else if (i_addr == dtpc_pkg::ADR_DONE) begin
			o_rdata <= DW'(done);
		end else if (i_addr == dtpc_pkg::ADR_STATUS) begin
			o_rdata <= DW'({o_irq_hold, act});
		end else if (in_bank(i_addr, dtpc_pkg::ADR_CTL_BASE)) begin
			o_rdata <= DW'(ctl[i_addr[CW-1:0]]);
		end else if (in_bank(i_addr, dtpc_pkg::ADR_CNT_BASE)) begin
			o_rdata <= cnt[i_addr[CW-1:0]];
		end else begin
			o_rdata <= '0;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_word_cycles: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		(state == dtpc_pkg::ST_XF1) && !abort ##1 !abort |-> (state == dtpc_pkg::ST_XF2))
		else $error("word transfer not two cycles");
	a_wait_follows: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		(state == dtpc_pkg::ST_XF2) && !abort |=> (state == dtpc_pkg::ST_WAIT))
		else $error("no wait cycle after word");
	a_bus_release: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		o_xfer_valid |-> $past(o_halt_req))
		else $error("transfer before halt");
	a_rmw_defer: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		$rose(o_halt_req) && $past(state == dtpc_pkg::ST_IDLE)
		&& $past(gctl[dtpc_pkg::GB_RMW]) |-> !$past(i_rmw_busy))
		else $error("halt during read-modify-write");
	a_halt_now: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		start && !gctl[dtpc_pkg::GB_RMW] && !abort |=> o_halt_req)
		else $error("halt not immediate");
	a_burst_gap: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		$rose(state == dtpc_pkg::ST_REL) && !abort |-> !o_halt_req [*2])
		else $error("burst release shorter than two cycles");
	a_no_preempt: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		(state != dtpc_pkg::ST_IDLE) && $past(state != dtpc_pkg::ST_IDLE) |-> $stable(act))
		else $error("running channel preempted");
	a_done_set: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		dec && last |=> done[$past(act)] && cnt[$past(act)] == tmp[$past(act)])
		else $error("count end without reload and done");
	a_nmi_stop: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		i_nmi && gctl[dtpc_pkg::GB_NMI] && o_irq_hold |=> !o_halt_req)
		else $error("nmi did not stop transfer");
	a_irq_held: assert property (
		@(posedge i_ref_clk) disable iff (i_reset)
		o_halt_req |-> o_irq_hold)
		else $error("interrupts open during transfer");
endmodule // dtpc_core

`default_nettype wire

// *** test/dtpc_far_model.sv ***
// Partner model: CPU bus release and peripheral trigger flags
`timescale 1ns/10ps
`default_nettype none

module dtpc_far_model (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset,
	// Bench controls
	input wire logic i_slow,
	input wire logic [15:0] i_raise,
	input wire logic [15:0] i_drop,
	input wire logic [15:0] i_irq_en,
	// Controller side
	input wire logic i_halt_req,
	input wire logic [15:0] i_src_clear,
	output logic o_bus_released,
	output var dtpc_pkg::dtpc_periph_type o_periph
);
	logic [1:0] lag;
	logic [15:0] flag;

	// Bus given up only after a halt request; slow CPU waits three more cycles
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			lag <= 2'h0;
			o_bus_released <= 1'b0;
		end else begin
			lag <= i_halt_req ? lag + {1'b0, lag != 2'h3} : 2'h0;
			o_bus_released <= i_halt_req && (!i_slow || lag == 2'h3);
		end
	end

	// Flags set by the bench, cleared when the controller starts on them
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			flag <= 16'h0000;
		end else begin
			flag <= (flag & ~i_src_clear & ~i_drop) | i_raise;
		end
	end

	// Conversion source never completes in hardware here
	always_comb begin
		o_periph = '{flag: flag, irq_en: i_irq_en, conv_hw: 1'b0};
	end
endmodule // dtpc_far_model

`default_nettype wire

// *** test/dtpc_tb_top.sv ***
// Testbench: self-checking bench of the DMA trigger and priority controller
`timescale 1ns/10ps
`default_nettype none

module dtpc_tb_top;
	logic clk, rst, wstb, rstb, ext, rmw, nmi, moff, slow, hreq, ihold, mrst, xv, bus;
	logic [4:0] addr;
	logic [15:0] wd, rdat, sclr, raise, drop, irqe, v;
	logic [2:0] xch;
	dtpc_pkg::dtpc_periph_type per;
	int err_count, checks, cyc, t0, t1, rel, n, seen[8], ord[$];
	bit mseen;

	dtpc_core uut (.i_ref_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd), .i_wr(wstb),
		.i_rd(rstb), .o_rdata(rdat), .i_periph(per), .i_ext_trig(ext), .o_src_clear(sclr),
		.o_conv_mem_read(), .i_bus_released(bus), .i_rmw_busy(rmw), .i_nmi(nmi),
		.o_halt_req(hreq), .o_irq_hold(ihold), .i_mclk_off(moff), .o_mclk_restart(mrst),
		.o_xfer_valid(xv), .o_xfer_chan(xch));
	dtpc_far_model far (.i_ref_clk(clk), .i_reset(rst), .i_slow(slow), .i_raise(raise),
		.i_drop(drop), .i_irq_en(irqe), .i_halt_req(hreq), .i_src_clear(sclr),
		.o_bus_released(bus), .o_periph(per));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Word log, CPU release cycles and clock restarts
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (xv === 1'b1) begin
			if (ord.size() == 0) t0 <= cyc;
			seen[xch] <= seen[xch] + 1;
			ord.push_back(int'(xch));
			t1 <= cyc;
		end
		if (ihold === 1'b1 && hreq === 1'b0) rel <= rel + 1;
		if (mrst === 1'b1) mseen <= 1'b1;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic hang_out();
		err_count++;
		$display("Error at %0t: wait ran out", $time);
		complete_run();
	endtask

	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wstb <= 1'b1;
		@(posedge clk);
		wstb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rstb <= 1'b1;
		@(posedge clk);
		rstb <= 1'b0;
		#1 d = rdat;
	endtask

	task automatic pulse(input logic [15:0] s, input logic [15:0] c);
		@(posedge clk);
		raise <= s;
		drop <= c;
		@(posedge clk);
		raise <= 16'h0000;
		drop <= 16'h0000;
	endtask

	// Idle means three quiet edges: a pending channel is granted from idle
	task automatic idle();
		int k, q;
		k = 0;
		q = 0;
		repeat (4) @(posedge clk);
		while (q < 3 && k < 300) begin
			@(posedge clk);
			k++;
			q = (ihold === 1'b0) ? q + 1 : 0;
		end
		if (q < 3) hang_out();
	endtask

	task automatic waitn(input int w);
		int k;
		k = 0;
		while (ord.size() < w && k < 300) begin
			@(posedge clk);
			k++;
		end
		if (ord.size() < w) hang_out();
	endtask

	// Control word: select, mode, software request, enable set
	function automatic logic [15:0] ctl(input logic [4:0] s, input logic [2:0] m, input logic w);
		return {5'h00, s, w, m, 1'b0, 1'b1};
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		{wstb, rstb, ext, rmw, nmi, moff, slow} = '0;
		{addr, wd, raise, drop, irqe} = '0;
		void'($urandom(32'h2685f7c2));
		repeat (12) @(posedge clk);
		chk(16'({hreq, ihold, xv, mrst}), 16'h0000);
		rst <= 1'b0;
		// Software request, single mode, clock restart from stopped
		reg_wr(5'h10, 16'h0002);
		moff <= 1'b1;
		reg_wr(5'h08, ctl(5'h00, 3'h0, 1'b0));
		reg_wr(5'h08, ctl(5'h00, 3'h0, 1'b1));
		idle();
		chk(16'(seen[0]), 16'h0001);
		reg_rd(5'h08, v);
		chk(v, 16'h0001);
		chk(16'(mseen), 16'h0001);
		chk(16'(mrst), 16'h0000);
		reg_wr(5'h08, ctl(5'h00, 3'h0, 1'b1));
		idle();
		reg_rd(5'h01, v);
		chk(v, 16'h0001);
		reg_rd(5'h08, v);
		chk(v, 16'h0000);
		reg_rd(5'h10, v);
		chk(v, 16'h0002);
		reg_wr(5'h01, 16'h00ff);
		moff <= 1'b0;
		// Stale flag, masked flag, then a clean edge; reserved select beside it
		slow <= 1'($urandom);
		pulse(16'h0002, 16'h0000);
		reg_wr(5'h11, 16'h00ff);
		reg_wr(5'h12, 16'h00ff);
		reg_wr(5'h09, ctl(5'h01, 3'h4, 1'b0));
		reg_wr(5'h0a, ctl(5'h1f, 3'h4, 1'b0));
		idle();
		chk(16'(seen[1]), 16'h0000);
		irqe <= 16'h0002;
		pulse(16'h0000, 16'h0002);
		pulse(16'h0002, 16'h0000);
		idle();
		chk(16'(seen[1]), 16'h0000);
		pulse(16'h0000, 16'h0002);
		irqe <= 16'h0000;
		pulse(16'h0002, 16'h0000);
		idle();
		chk(16'(seen[1]), 16'h0001);
		chk(16'(per.flag[1]), 16'h0000);
		chk(16'(seen[2]), 16'h0000);
		// Two pending channels, fixed then rotating order
		reg_wr(5'h13, 16'h00ff);
		reg_wr(5'h14, 16'h00ff);
		reg_wr(5'h0b, ctl(5'h02, 3'h4, 1'b0));
		reg_wr(5'h0c, ctl(5'h03, 3'h4, 1'b0));
		for (int r = 0; r < 2; r++) begin
			reg_wr(5'h00, 16'(r));
			pulse(16'h0004, 16'h0000);
			idle();
			ord.delete();
			pulse(16'h000c, 16'h0000);
			idle();
			chk(16'(ord.size()), 16'h0002);
			chk(16'(ord[0]), (r == 1) ? 16'h0004 : 16'h0003);
		end
		reg_wr(5'h00, 16'h0000);
		// Block of random length from one trigger; a second trigger mid-block
		n = 3 + int'($urandom % 4);
		reg_wr(5'h15, 16'(n));
		reg_wr(5'h0d, ctl(5'h04, 3'h1, 1'b0));
		ord.delete();
		pulse(16'h0010, 16'h0000);
		repeat (6) @(posedge clk);
		pulse(16'h0010, 16'h0000);
		idle();
		chk(16'(ord.size()), 16'(n));
		chk(16'(t1 - t0), 16'(3 * (n - 1)));
		reg_rd(5'h0d, v);
		chk(v & 16'h0001, 16'h0000);
		// Repeated burst with slow CPU, stopped by the non-maskable interrupt
		slow <= 1'b1;
		reg_wr(5'h00, 16'h0002);
		reg_wr(5'h16, 16'h0005);
		ord.delete();
		rel <= 0;
		reg_wr(5'h0e, ctl(5'h05, 3'h6, 1'b0));
		pulse(16'h0020, 16'h0000);
		waitn(5);
		chk(16'(rel), 16'h0002);
		waitn(7);
		chk(16'(ihold), 16'h0001);
		reg_rd(5'h0e, v);
		chk(v & 16'h0001, 16'h0001);
		nmi <= 1'b1;
		@(posedge clk);
		nmi <= 1'b0;
		idle();
		n = ord.size();
		repeat (20) @(posedge clk);
		chk(16'(ord.size()), 16'(n));
		reg_wr(5'h0e, 16'h0000);
		// Halt deferred while the CPU is in a read-modify-write, then not
		slow <= 1'($urandom);
		reg_wr(5'h00, 16'h0004);
		reg_wr(5'h17, 16'h00ff);
		reg_wr(5'h0f, ctl(5'h06, 3'h4, 1'b0));
		rmw <= 1'b1;
		pulse(16'h0040, 16'h0000);
		repeat (8) @(posedge clk);
		chk(16'(hreq), 16'h0000);
		rmw <= 1'b0;
		idle();
		chk(16'(seen[7]), 16'h0001);
		reg_wr(5'h00, 16'h0000);
		rmw <= 1'b1;
		pulse(16'h0040, 16'h0000);
		idle();
		chk(16'(seen[7]), 16'h0002);
		rmw <= 1'b0;
		// Level block on the external pin, freeze and resume; chain and conversion
		reg_wr(5'h09, ctl(5'h0a, 3'h4, 1'b0));
		reg_wr(5'h0a, ctl(5'h08, 3'h4, 1'b0));
		pulse(16'h0100, 16'h0000);
		reg_wr(5'h10, 16'h0006);
		reg_wr(5'h08, ctl(5'h0b, 3'h1, 1'b0) | 16'h0002);
		ord.delete();
		ext <= 1'b1;
		waitn(2);
		ext <= 1'b0;
		idle();
		chk(16'(ord.size()), 16'h0002);
		chk(16'(seen[2]), 16'h0000);
		reg_rd(5'h10, v);
		chk(v, 16'h0004);
		ext <= 1'b1;
		idle();
		chk(16'(ord.size()), 16'h0007);
		chk(16'(seen[1]), 16'h0002);
		reg_rd(5'h01, v);
		chk(v & 16'h0001, 16'h0001);
		ext <= 1'b0;
		complete_run();
	end
endmodule // dtpc_tb_top

`default_nettype wire
